// *** alarm_summary_autotune_regs_test.sv ***
// Self-checking bench of the alarm summary and autotune register bank
`timescale 1ns/100ps
`default_nettype none
`include "ast_regs_map.svh"
module alarm_summary_autotune_regs_test;
   import ast_pkg::*;
   localparam int NCH = 2;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic wr, rd, rvalid;
   logic rise_done = 1'b0;
   logic [7:0] index;
   logic [15:0] wdata, rdata, e, sp;
   ast_chan_alarm_t alarms [NCH];
   ast_chan_ctl_t ctl [NCH];
   ast_chan_ctl_t good;
   logic [NCH-1:0] tdone = '0;
   logic [NCH-1:0] tabandon = '0;
   logic [NCH-1:0] tuning;
   logic [47:0] tpid [NCH];
   logic [15:0] spo [NCH];
   logic [7:0] b;
   int err_count = 0;
   int checks_done = 0;
   int c;

   always #2.5 clk_sys_in = ~clk_sys_in;

   ast_host ast_host_i (.clk_sys_in(clk_sys_in), .wr_out(wr), .rd_out(rd),
      .index_out(index), .wdata_out(wdata));
   ast_regs #(.NCH(NCH)) ast_regs_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .wr_in(wr), .rd_in(rd), .index_in(index), .wdata_in(wdata),
      .rise_done_in(rise_done), .alarms_in(alarms), .ctl_in(ctl),
      .tune_done_in(tdone), .tune_abandon_in(tabandon), .tuned_pid_in(tpid),
      .rdata_out(rdata), .rvalid_out(rvalid), .tuning_out(tuning), .setpoint_out(spo));

   task automatic tick();
      @(posedge clk_sys_in);
      #1;
   endtask

   task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // ****************************************************************
   // Read data monitor
   // ****************************************************************
   always @(negedge clk_sys_in) begin
      if (rvalid === 1'b1) begin
         if (ast_host_i.exp_q.size() == 0) begin
            err_count++;
            $display("[FAIL] read data expected none seen %h", rdata);
         end else begin
            chk16(ast_host_i.name_q.pop_front(), ast_host_i.exp_q.pop_front(), rdata);
         end
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Starts tuning on channel c and confirms it runs
   task automatic start_tune();
      ast_host_i.wr(b + `AST_IDX_TUNING_SELECT, 16'h0001);
      repeat (3) tick();
      ast_host_i.rd(b + `AST_IDX_TUNING_SELECT, 16'h0001, "select on");
      chk16("tuning out", 16'h0001, 16'(tuning[c]));
   endtask

   initial begin
      good = '0;
      good.auto_mode = 1'b1;
      good.run_mode = 1'b1;
      good.op_mode_normal = 1'b1;
      good.measured_value = 16'h0100;
      good.err_point_low = 16'h0010;
      good.err_point_high = 16'h1000;
      good.out_lim_high = 16'h03E8;
      good.set_lim_low = 16'h0010;
      good.set_lim_high = 16'h0100;
      for (int i = 0; i < NCH; i++) begin
         alarms[i] = '0;
         ctl[i] = good;
         tpid[i] = 48'h0000_1234_5678 + 48'(i);
      end
      void'($urandom(89757));
      repeat (3) @(posedge clk_sys_in);
      #1;
      reset_in = 1'b0;
      tick();
      // Reset values and unmapped index
      ast_host_i.rd(`AST_IDX_ALARM_SUMMARY, 16'h0000, "summary reset");
      for (c = 0; c < NCH; c++) begin
         b = 8'((c + 1) * 8);
         ast_host_i.rd(b + `AST_IDX_TEMP_SETPOINT, `AST_RST_SETPOINT, "sp reset");
         ast_host_i.rd(b + `AST_IDX_MOTOR_SETPOINT, 16'h0000, "motor reset");
         ast_host_i.rd(b + `AST_IDX_TUNING_SELECT, `AST_RST_TUNING, "sel reset");
      end
      ast_host_i.wr(8'h07, 16'hABCD);
      ast_host_i.rd(8'h07, 16'h0000, "unmapped");
      $display("test reset values done");
      // Each alarm class on a random channel, then all at once
      for (int j = 0; j < 10; j++) begin
         c = $urandom_range(NCH - 1);
         alarms[c] = ast_chan_alarm_t'(10'h200 >> j);
         rise_done = j[0];
         repeat (2) tick();
         e = 16'h0001 << ((j < 4) ? j : j + 1);
         if (j[0]) e = e | 16'h0010;
         ast_host_i.rd(`AST_IDX_ALARM_SUMMARY, e, "summary bit");
         alarms[c] = '0;
      end
      alarms[NCH-1] = '1;
      rise_done = 1'b1;
      repeat (2) tick();
      ast_host_i.rd(`AST_IDX_ALARM_SUMMARY, 16'h07FF, "summary all");
      alarms[NCH-1] = '0;
      rise_done = 1'b0;
      $display("test alarm summary done");
      // Setpoints inside, on and outside the limiter range
      for (c = 0; c < NCH; c++) begin
         b = 8'((c + 1) * 8);
         sp = 16'($urandom_range(16'h00FF, 16'h0010));
         ast_host_i.wr(b + `AST_IDX_TEMP_SETPOINT, sp);
         ast_host_i.rd(b + `AST_IDX_TEMP_SETPOINT, sp, "sp");
         ast_host_i.wr(b + `AST_IDX_TEMP_SETPOINT, 16'h0101);
         ast_host_i.wr(b + `AST_IDX_TEMP_SETPOINT, 16'h000F);
         ast_host_i.rd(b + `AST_IDX_SETPOINT_MON, sp, "sp refused");
         ast_host_i.wr(b + `AST_IDX_TEMP_SETPOINT, 16'h0100);
         ast_host_i.rd(b + `AST_IDX_TEMP_SETPOINT, 16'h0100, "sp edge");
         chk16("setpoint out", 16'h0100, spo[c]);
         ast_host_i.wr(b + `AST_IDX_MOTOR_SETPOINT, sp);
         ast_host_i.rd(b + `AST_IDX_MOTOR_SETPOINT, sp, "motor sp");
      end
      $display("test setpoints done");
      // Start refused for each unmet precondition except measured value at the high error point
      for (int k = 0; k < 7; k++) begin
         c = k % NCH;
         b = 8'((c + 1) * 8);
         case (k)
            0: ctl[c].auto_mode = 1'b0;
            1: ctl[c].run_mode = 1'b0;
            2: ctl[c].measured_value = good.err_point_low;
            3: ctl[c].out_lim_high = `AST_OUT_LIM_LOW_PERMIL;
            4: ctl[c].out_lim_low = `AST_OUT_LIM_HIGH_PERMIL;
            5: ctl[c].op_mode_normal = 1'b0;
            default: ctl[c].fail = 1'b1;
         endcase
         ast_host_i.wr(b + `AST_IDX_TUNING_SELECT, 16'h0001);
         repeat (3) tick();
         ast_host_i.rd(b + `AST_IDX_TUNING_SELECT, 16'h0000, "sel refused");
         chk16("tuning refused", 16'h0000, 16'(tuning[c]));
         ctl[c] = good;
      end
      $display("test refused start done");
      // Tuning ended by every stop cause except measured value at the low error point, and by completion
      for (int k = 0; k < 9; k++) begin
         c = k % NCH;
         b = 8'((c + 1) * 8);
         start_tune();
         case (k)
            0: ctl[c].auto_mode = 1'b0;
            1: ctl[c].run_mode = 1'b0;
            2: ctl[c].fail = 1'b1;
            3: ctl[c].op_mode_normal = 1'b0;
            4: ctl[c].measured_value = good.err_point_high;
            5: ast_host_i.wr(b + `AST_IDX_TEMP_SETPOINT, 16'h0020);
            6: ast_host_i.wr(b + `AST_IDX_TUNING_SELECT, 16'h0000);
            7: tabandon[c] = 1'b1;
            default: tdone[c] = 1'b1;
         endcase
         tick();
         tabandon = '0;
         tdone = '0;
         repeat (3) tick();
         ast_host_i.rd(b + `AST_IDX_TUNING_SELECT, 16'h0000, "sel back");
         chk16("tuning stop", 16'h0000, 16'(tuning[c]));
         ctl[c] = good;
      end
      $display("test tuning stop done");
      for (int n = 0; n < 20 && ast_host_i.exp_q.size() > 0; n++) tick();
      if (ast_host_i.exp_q.size() > 0) begin
         err_count++;
         $display("[FAIL] read answers expected %0d seen 0", ast_host_i.exp_q.size());
      end
      complete_run();
   end
endmodule
`default_nettype wire

// *** ast_alarm_or.sv ***
// OR reduction of every alarm class across all channels into the summary word
`timescale 1ns/100ps
`default_nettype none
`include "ast_regs_map.svh"
module ast_alarm_or #(
   parameter int NCH = 4
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire ast_pkg::ast_chan_alarm_t alarms_in [NCH],
   input wire logic rise_done_in,
   output logic [15:0] summary_out
);
   import ast_pkg::*;
   logic [NCH-1:0] cls [10];
   logic [15:0] summary_nxt;
   logic [15:0] summary_r;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         assign cls[0][g] = alarms_in[g].alarm1;
         assign cls[1][g] = alarms_in[g].alarm2;
         assign cls[2][g] = alarms_in[g].burnout;
         assign cls[3][g] = alarms_in[g].heater_break;
         assign cls[4][g] = alarms_in[g].analog_input_alarm1;
         assign cls[5][g] = alarms_in[g].analog_input_alarm2;
         assign cls[6][g] = alarms_in[g].control_loop_break_alarm;
         assign cls[7][g] = alarms_in[g].secondary_input_alarm1;
         assign cls[8][g] = alarms_in[g].secondary_input_alarm2;
         assign cls[9][g] = alarms_in[g].secondary_input_burnout;
      end
   endgenerate

   always_comb begin
      summary_nxt = 16'h0000;
      summary_nxt[0] = |cls[0];
      summary_nxt[1] = |cls[1];
      summary_nxt[2] = |cls[2];
      summary_nxt[3] = |cls[3];
      summary_nxt[4] = rise_done_in;
      summary_nxt[5] = |cls[4];
      summary_nxt[6] = |cls[5];
      summary_nxt[7] = |cls[6];
      summary_nxt[8] = |cls[7];
      summary_nxt[9] = |cls[8];
      summary_nxt[10] = |cls[9];
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         summary_r <= 16'h0000;
      end else begin
         summary_r <= summary_nxt;
      end
   end
   assign summary_out = summary_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_sum_unused;
      @(posedge clk_sys_in) disable iff (reset_in) summary_r[15:11] == 5'h00;
   endproperty
   a_sum_unused: assert property (p_sum_unused) else $error("unused summary bits set");

   property p_sum_alarm1;
      @(posedge clk_sys_in) disable iff (reset_in) ##1 summary_r[0] == $past(|cls[0]);
   endproperty
   a_sum_alarm1: assert property (p_sum_alarm1) else $error("alarm1 summary wrong");

   property p_sum_rise;
      @(posedge clk_sys_in) disable iff (reset_in) $rose(rise_done_in) |=> summary_r[4];
   endproperty
   a_sum_rise: assert property (p_sum_rise) else $error("rise bit not set");

   property p_sum_lba;
      @(posedge clk_sys_in) disable iff (reset_in) ##1 summary_r[7] == $past(|cls[6]);
   endproperty
   a_sum_lba: assert property (p_sum_lba) else $error("loop break summary wrong");

   property p_sum_ti;
      @(posedge clk_sys_in) disable iff (reset_in)
         ##1 summary_r[10:8] == {$past(|cls[9]), $past(|cls[8]), $past(|cls[7])};
   endproperty
   a_sum_ti: assert property (p_sum_ti) else $error("secondary summary wrong");

   property p_sum_ai;
      @(posedge clk_sys_in) disable iff (reset_in)
         ##1 summary_r[6:5] == {$past(|cls[5]), $past(|cls[4])};
   endproperty
   a_sum_ai: assert property (p_sum_ai) else $error("analog summary wrong");
endmodule
`default_nettype wire

// *** ast_host.sv ***
// Bus master model: issues register writes and reads and notes expected read data
`timescale 1ns/100ps
`default_nettype none
module ast_host (
   input wire logic clk_sys_in,
   output logic wr_out,
   output logic rd_out,
   output logic [7:0] index_out,
   output logic [15:0] wdata_out
);
   logic [15:0] exp_q [$];
   string name_q [$];

   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      index_out = 8'h00;
      wdata_out = 16'hFFFF;
   end

   // ****************************************************************
   // Register cycles
   // ****************************************************************
   // A tuning start is issued by the caller both when the channel is ready and when a precondition is unmet
   task automatic wr(input logic [7:0] idx, input logic [15:0] val);
      @(posedge clk_sys_in);
      #1;
      wr_out = 1'b1;
      index_out = idx;
      wdata_out = val;
      @(posedge clk_sys_in);
      #1;
      wr_out = 1'b0;
      wdata_out = ~val;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [15:0] exp, input string nm);
      @(posedge clk_sys_in);
      #1;
      rd_out = 1'b1;
      index_out = idx;
      exp_q.push_back(exp);
      name_q.push_back(nm);
      @(posedge clk_sys_in);
      #1;
      rd_out = 1'b0;
      index_out = ~idx;
   endtask
endmodule
`default_nettype wire

// *** ast_pkg.sv ***
// Types shared by the alarm summary and autotune register bank
package ast_pkg;
   typedef struct packed {
      logic alarm1;
      logic alarm2;
      logic burnout;
      logic heater_break;
      logic analog_input_alarm1;
      logic analog_input_alarm2;
      logic control_loop_break_alarm;
      logic secondary_input_alarm1;
      logic secondary_input_alarm2;
      logic secondary_input_burnout;
   } ast_chan_alarm_t;

   typedef struct packed {
      logic auto_mode;
      logic run_mode;
      logic op_mode_normal;
      logic fail;
      logic [15:0] measured_value;
      logic [15:0] err_point_low;
      logic [15:0] err_point_high;
      logic [15:0] out_lim_high;
      logic [15:0] out_lim_low;
      logic [15:0] set_lim_low;
      logic [15:0] set_lim_high;
   } ast_chan_ctl_t;

   typedef enum logic [2:0] {
      AST_IDLE = 3'b001,
      AST_TUNE = 3'b010,
      AST_DONE = 3'b100
   } ast_tune_state_t;
endpackage

// *** ast_regs.sv ***
// Holding-register bank: alarm summary, setpoints and per-channel tuning selector
`timescale 1ns/100ps
`default_nettype none
`include "ast_regs_map.svh"
module ast_regs #(
   parameter int NCH = 4
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] index_in,
   input wire logic [15:0] wdata_in,
   input wire logic rise_done_in,
   input wire ast_pkg::ast_chan_alarm_t alarms_in [NCH],
   input wire ast_pkg::ast_chan_ctl_t ctl_in [NCH],
   input wire logic [NCH-1:0] tune_done_in,
   input wire logic [NCH-1:0] tune_abandon_in,
   input wire logic [47:0] tuned_pid_in [NCH],
   output logic [15:0] rdata_out,
   output logic rvalid_out,
   output logic [NCH-1:0] tuning_out,
   output logic [15:0] setpoint_out [NCH]
);
   import ast_pkg::*;

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [15:0] summary;
   logic [15:0] sp_r [NCH];
   logic [15:0] sp_nxt [NCH];
   logic [15:0] msp_r [NCH];
   logic [15:0] msp_nxt [NCH];
   logic [NCH-1:0] sp_chg;
   logic [NCH-1:0] sel_wr;
   logic [NCH-1:0] tun;
   logic [NCH-1:0] tun_r;
   logic [15:0] rdata_nxt, rdata_r;
   logic rvalid_r;
   logic [15:0] sp_o_r [NCH];

   ast_alarm_or #(.NCH(NCH)) u_or (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .alarms_in(alarms_in),
      .rise_done_in(rise_done_in),
      .summary_out(summary)
   );

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         localparam logic [7:0] BASE = 8'((g + 1) * `AST_CH_STRIDE);
         logic in_lim;
         assign in_lim = wdata_in >= ctl_in[g].set_lim_low && wdata_in <= ctl_in[g].set_lim_high;
         always_comb begin
            sp_nxt[g] = sp_r[g];
            msp_nxt[g] = msp_r[g];
            sp_chg[g] = 1'b0;
            if (wr_in && index_in == BASE + `AST_IDX_TEMP_SETPOINT && in_lim) begin
               sp_nxt[g] = wdata_in;
               sp_chg[g] = (wdata_in != sp_r[g]);
            end
            if (wr_in && index_in == BASE + `AST_IDX_MOTOR_SETPOINT && in_lim) begin
               msp_nxt[g] = wdata_in;
            end
         end
         assign sel_wr[g] = wr_in && index_in == BASE + `AST_IDX_TUNING_SELECT;
         always_ff @(posedge clk_sys_in or posedge reset_in) begin
            if (reset_in) begin
               sp_r[g] <= `AST_RST_SETPOINT;
               msp_r[g] <= `AST_RST_SETPOINT;
               sp_o_r[g] <= `AST_RST_SETPOINT;
            end else begin
               sp_r[g] <= sp_nxt[g];
               msp_r[g] <= msp_nxt[g];
               sp_o_r[g] <= sp_nxt[g];
            end
         end
         ast_tune_chan u_tc (
            .clk_sys_in(clk_sys_in),
            .reset_in(reset_in),
            .ctl_in(ctl_in[g]),
            .sel_wr_in(sel_wr[g]),
            .sel_val_in(wdata_in[0]),
            .sp_changed_in(sp_chg[g]),
            .tune_done_in(tune_done_in[g]),
            .tune_abandon_in(tune_abandon_in[g]),
            .tuned_pid_in(tuned_pid_in[g]),
            .pid_wr_data_in(48'h0),
            .pid_wr_in(1'b0),
            .tuning_out(tun[g]),
            .pid_out()
         );
         assign setpoint_out[g] = sp_o_r[g];
      end
   endgenerate

   // ****************************************************************
   // Read path
   // ****************************************************************
   always_comb begin
      rdata_nxt = 16'h0000;
      if (index_in == `AST_IDX_ALARM_SUMMARY) begin
         rdata_nxt = summary;
      end
      for (int i = 0; i < NCH; i++) begin
         if (index_in == 8'((i + 1) * `AST_CH_STRIDE) + `AST_IDX_SETPOINT_MON) begin
            rdata_nxt = sp_r[i];
         end
         if (index_in == 8'((i + 1) * `AST_CH_STRIDE) + `AST_IDX_TEMP_SETPOINT) begin
            rdata_nxt = sp_r[i];
         end
         if (index_in == 8'((i + 1) * `AST_CH_STRIDE) + `AST_IDX_MOTOR_SETPOINT) begin
            rdata_nxt = msp_r[i];
         end
         if (index_in == 8'((i + 1) * `AST_CH_STRIDE) + `AST_IDX_TUNING_SELECT) begin
            rdata_nxt = {15'h0000, tun[i]};
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_r <= 16'h0000;
         rvalid_r <= 1'b0;
         tun_r <= '0;
      end else begin
         rdata_r <= rd_in ? rdata_nxt : rdata_r;
         rvalid_r <= rd_in;
         tun_r <= tun;
      end
   end
   assign rdata_out = rdata_r;
   assign rvalid_out = rvalid_r;
   assign tuning_out = tun_r;

   property p_sel_reset;
      @(posedge clk_sys_in) disable iff (reset_in)
         (sel_wr[0] && !wdata_in[0]) |-> ##2 !tuning_out[0];
   endproperty
   a_sel_reset: assert property (p_sel_reset) else $error("selector not PID");

   property p_sp_limit;
      @(posedge clk_sys_in) disable iff (reset_in)
         (wr_in && index_in == `AST_CH_STRIDE + `AST_IDX_TEMP_SETPOINT
          && wdata_in > ctl_in[0].set_lim_high) |=> $stable(sp_r[0]);
   endproperty
   a_sp_limit: assert property (p_sp_limit) else $error("setpoint out of limit");

   c_read: cover property (@(posedge clk_sys_in) rd_in && index_in == `AST_IDX_ALARM_SUMMARY);
endmodule
`default_nettype wire

// *** ast_regs_map.svh ***
// Register map, field positions and reset values of the alarm summary bank
//
// Contract
// - Bits 0-3 OR alarm1, alarm2, burnout, heater break
// - Bit 4 is temperature rise completion
// - Bits 5-6 OR analog input alarms
// - Bit 7 ORs control loop break alarm
// - Bits 8-10 OR secondary input alarms
// - Bits 11-15 read zero, 1 is active
// - Setpoint accepts only values within limiter range
// - Selector: 0 PID, 1 autotuning, default 0
// - Autotuning loads computed PID constants
// - Measured value strictly inside error points
// - Limiter high above 0.1%, low below 99.9%
// - Operation mode must be normal
// - Completion clears selector back to PID
// - Slow process may abandon tuning early
// - Stop condition aborts, restores start PID constants
`ifndef AST_REGS_MAP_SVH
`define AST_REGS_MAP_SVH

// ****************************************************************
// Register indices (per unit, then per channel)
// ****************************************************************
`define AST_IDX_ALARM_SUMMARY 8'h00
`define AST_IDX_SETPOINT_MON 8'h01
`define AST_IDX_TEMP_SETPOINT 8'h02
`define AST_IDX_MOTOR_SETPOINT 8'h03
`define AST_IDX_TUNING_SELECT 8'h04
`define AST_CH_STRIDE 8'h08

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define AST_RST_SETPOINT 16'h0000
`define AST_RST_TUNING 16'h0000
`define AST_SUMMARY_USED 11
`define AST_OUT_LIM_LOW_PERMIL 16'h0001
`define AST_OUT_LIM_HIGH_PERMIL 16'h03E7
`define AST_SEL_PID 1'b0
`define AST_SEL_TUNE 1'b1

`endif

// *** ast_tune_chan.sv ***
// Per-channel autotune selector, start checks, stop conditions and PID snapshot
`timescale 1ns/100ps
`default_nettype none
`include "ast_regs_map.svh"
module ast_tune_chan (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire ast_pkg::ast_chan_ctl_t ctl_in,
   input wire logic sel_wr_in,
   input wire logic sel_val_in,
   input wire logic sp_changed_in,
   input wire logic tune_done_in,
   input wire logic tune_abandon_in,
   input wire logic [47:0] tuned_pid_in,
   input wire logic [47:0] pid_wr_data_in,
   input wire logic pid_wr_in,
   output logic tuning_out,
   output logic [47:0] pid_out
);
   import ast_pkg::*;
   ast_tune_state_t st_r, st_nxt;
   logic [47:0] pid_r, pid_nxt, snap_r, snap_nxt;
   logic pre_ok, stop;

   always_comb begin
      pre_ok = ctl_in.auto_mode && ctl_in.run_mode
         && ctl_in.measured_value > ctl_in.err_point_low
         && ctl_in.measured_value < ctl_in.err_point_high
         && ctl_in.out_lim_high > `AST_OUT_LIM_LOW_PERMIL
         && ctl_in.out_lim_low < `AST_OUT_LIM_HIGH_PERMIL
         && ctl_in.op_mode_normal && !ctl_in.fail;
      stop = !ctl_in.auto_mode || !ctl_in.run_mode || !ctl_in.op_mode_normal || ctl_in.fail
         || ctl_in.measured_value >= ctl_in.err_point_high
         || ctl_in.measured_value <= ctl_in.err_point_low
         || sp_changed_in || tune_abandon_in
         || (sel_wr_in && sel_val_in == `AST_SEL_PID);
      st_nxt = st_r;
      pid_nxt = pid_wr_in ? pid_wr_data_in : pid_r;
      snap_nxt = snap_r;
      case (st_r)
         AST_IDLE: begin
            if (sel_wr_in && sel_val_in == `AST_SEL_TUNE && pre_ok) begin
               st_nxt = AST_TUNE;
               snap_nxt = pid_r;
            end
         end
         AST_TUNE: begin
            if (stop) begin
               st_nxt = AST_IDLE;
               pid_nxt = snap_r;
            end else if (tune_done_in) begin
               st_nxt = AST_DONE;
               pid_nxt = tuned_pid_in;
            end
         end
         AST_DONE: begin
            st_nxt = AST_IDLE;
         end
         default: begin
            st_nxt = AST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         st_r <= AST_IDLE;
         pid_r <= 48'h0;
         snap_r <= 48'h0;
      end else begin
         st_r <= st_nxt;
         pid_r <= pid_nxt;
         snap_r <= snap_nxt;
      end
   end
   assign tuning_out = (st_r == AST_TUNE);
   assign pid_out = pid_r;

   property p_refuse;
      @(posedge clk_sys_in) disable iff (reset_in)
         (st_r == AST_IDLE && sel_wr_in && sel_val_in && !pre_ok) |=> st_r == AST_IDLE;
   endproperty
   a_refuse: assert property (p_refuse) else $error("start accepted unmet");

   property p_done_back;
      @(posedge clk_sys_in) disable iff (reset_in)
         (st_r == AST_TUNE && !stop && tune_done_in) |=> ##1 st_r == AST_IDLE;
   endproperty
   a_done_back: assert property (p_done_back) else $error("no return to PID");

   property p_restore;
      @(posedge clk_sys_in) disable iff (reset_in)
         (st_r == AST_TUNE && stop) |=> (st_r == AST_IDLE && pid_r == $past(snap_r));
   endproperty
   a_restore: assert property (p_restore) else $error("PID not restored");

   property p_load;
      @(posedge clk_sys_in) disable iff (reset_in)
         (st_r == AST_TUNE && !stop && tune_done_in) |=> pid_r == $past(tuned_pid_in);
   endproperty
   a_load: assert property (p_load) else $error("tuned PID not loaded");

   c_start: cover property (@(posedge clk_sys_in) st_r == AST_IDLE ##1 st_r == AST_TUNE);
   c_done: cover property (@(posedge clk_sys_in) st_r == AST_DONE);
   c_abort: cover property (@(posedge clk_sys_in) st_r == AST_TUNE && stop);
endmodule
`default_nettype wire
